// ===== hw/vpr_check.sv
// Combinational access and length checker for one page
`timescale 1ns/1ps
module vpr_check
  import vpr_pkg::*;
(
  // Page descriptor and reference
  input wire logic [15:0] desc,
  input wire logic [6:0] blockNum,
  input wire logic isWrite,
  // Verdict
  output logic abortAcc,
  output logic abortLen,
  output logic abortRo,
  output logic trapHit
);
  logic [2:0] acc;
  logic [6:0] len;
  always_comb
  begin
    acc = desc[2:0];
    len = desc[14:8];
    // Codes 000, 011, 111 abort every access
    abortAcc = (acc == 3'h0) || (acc == 3'h3) || (acc == 3'h7);
    // Read-only pages refuse writes
    abortRo = isWrite && (acc == 3'h1 || acc == 3'h2);
    // Trap on read for 001 and 100, on write for 100 and 101
    trapHit = (!isWrite && (acc == 3'h1 || acc == 3'h4)) ||
      (isWrite && (acc == 3'h4 || acc == 3'h5));
    // Direction picks which side of the length field is legal
    abortLen = desc[3] ? (blockNum < len) : (blockNum > len);
  end
endmodule : vpr_check

// ===== hw/vpr_pkg.sv
// Types shared by the relocation unit
package vpr_pkg;
  typedef enum logic [1:0] {
    VPR_KERNEL = 2'h0,
    VPR_SUPER = 2'h1,
    VPR_BADMODE = 2'h2,
    VPR_USER = 2'h3
  } vpr_mode_t;
  typedef enum logic [2:0] {
    VPR_ST_IDLE = 3'h1,
    VPR_ST_INSTR = 3'h2,
    VPR_ST_VECTOR = 3'h4
  } vpr_state_t;
endpackage : vpr_pkg

// ===== hw/vpr_regs.svh
// Register offsets, field positions, reset values and trap vector for relocation
`ifndef VPR_REGS_SVH
`define VPR_REGS_SVH
// Register selector encoding on the register port
`define VPR_SEL_BASE 2'h0
`define VPR_SEL_DESC 2'h1
`define VPR_SEL_MAIN 2'h2
`define VPR_SEL_DSPACE 2'h3
// Descriptor field positions
`define VPR_DESC_ACC_LO 0
`define VPR_DESC_DIR 3
`define VPR_DESC_WRIT 6
`define VPR_DESC_ACCD 7
`define VPR_DESC_LEN_LO 8
`define VPR_DESC_WMASK 16'h7_F0F
// Page base reserved bits mask; base writes and reads keep bits 15-12 unmasked
`define VPR_BASE_MASK 16'h0_FFF
// Main status fields
`define VPR_MAIN_EN 0
`define VPR_MAIN_TRAPEN 9
`define VPR_MAIN_WMASK 16'h0_301
`define VPR_MAIN_RST 16'h0_080
`define VPR_DSPACE_RST 3'h0
// Trap vector of the management unit in kernel space
`define VPR_TRAP_VEC 16'h0_0A8
`endif

// ===== hw/vpr_unit.sv
// Virtual page relocation unit: 16-bit virtual to 18-bit physical
//Contract
// - With relocation on, vectors are kernel virtual addresses via kernel set.
// - Old PC/status pushed to stack of mode in new status bits 15,14.
// - New status mode bits select the register set afterwards; the unit selects by curMode, and the latched vecMode is never used.
// - Fetches, index, absolute, immediate use I space; others use D space.
// - D space disabled for a mode maps everything through I space.
// - Eight base and descriptor registers per space per mode.
// - Address splits into 3-bit page select, 13-bit displacement.
// - Displacement is 7-bit block number then 6-bit block offset.
// - Page base holds 12-bit physical block number in 32-word units.
// - Physical block = virtual block + base; append offset, 18 bits.
// - Page base bits 15-12 take no part in address formation.
// - Codes 000, 011, 111 abort every access.
// - Codes 001, 010 abort writes; 001 traps on reads.
// - 100 traps any access, 101 writes only, 110 free.
// - Aborts do not complete; traps taken after instruction ends.
// - Accessed flag bit 7 set when access meets trap condition.
// - Written flag bit 6 set when a word in the page is modified.
// - Writing base or descriptor clears both flags.
// - Descriptor bit 3 picks upward or downward growth.
// - Length field bits 14-8: length-1 upward, 128-length downward.
// - Length error aborts outside the length field bound.
// - Descriptor bits 15, 5, 4 always read zero.
// - Relocation and checks only while main status bit 0 set.
// - Data space enable per mode: bit0 user, bit1 super, bit2 kernel.
// - Abort flags 15-13 freeze recorded fault page information.
// - Traps taken only with bit 9 set; flags still logged.
`timescale 1ns/1ps
`include "vpr_regs.svh"
module vpr_unit
  import vpr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Core reference
  input wire logic refValid,
  input wire logic [15:0] virtAddr,
  input wire logic [1:0] curMode,
  input wire logic isInstr,
  input wire logic isWrite,
  // Instruction boundaries and vectored transfers
  input wire logic instrEnd,
  input wire logic vecStart,
  input wire logic [15:0] vecNewStatus,
  // Relocated answer
  output logic [17:0] physAddr,
  output logic refAbort,
  output logic trapPending,
  output logic [1:0] mapMode,
  output logic [1:0] stackMode,
  output logic takeTrap,
  // Register port
  input wire logic regWrite,
  input wire logic [1:0] regSel,
  input wire logic [1:0] regMode,
  input wire logic regDspace,
  input wire logic [2:0] regPage,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata
);
  typedef struct packed {
    logic [47:0][15:0] base;
    logic [47:0][15:0] desc;
    logic [15:0] main;
    logic [2:0] dspace;
    logic trapReq;
    logic vecPhase;
    logic [1:0] vecMode;
    vpr_state_t state;
  } vpr_state_s_t;
  vpr_state_s_t s_q, s_d;

  // Flat register index: mode, space, page
  function automatic logic [5:0] regIdx(input logic [1:0] m,
                                        input logic d,
                                        input logic [2:0] p);
    logic [1:0] mm;
    mm = (m == 2'h3) ? 2'h2 : m;
    regIdx = {mm, d, p};
  endfunction : regIdx

  logic relocOn;
  logic [1:0] effMode;
  logic useD;
  logic [5:0] idx;
  logic [15:0] curDesc;
  logic [11:0] curBase;
  logic [11:0] physBlock;
  logic cAcc, cLen, cRo, cTrap, badMode, abortAny;

  // Vector fetches during a transfer use kernel mode
  always_comb
  begin
    relocOn = s_q.main[`VPR_MAIN_EN];
    effMode = vecStart || s_q.vecPhase ? 2'h0 : curMode;
    badMode = relocOn && (effMode == 2'h2);
    // D space only when this mode has it enabled
    case (effMode)
      2'h0: useD = !isInstr && s_q.dspace[2];
      2'h1: useD = !isInstr && s_q.dspace[1];
      default: useD = !isInstr && s_q.dspace[0];
    endcase
    idx = regIdx(effMode, useD, virtAddr[15:13]);
    curDesc = s_q.desc[idx];
    curBase = s_q.base[idx][11:0];
    physBlock = curBase + {5'h00, virtAddr[12:6]};
  end

  vpr_check uCheck (
    .desc(curDesc),
    .blockNum(virtAddr[12:6]),
    .isWrite(isWrite),
    .abortAcc(cAcc),
    .abortLen(cLen),
    .abortRo(cRo),
    .trapHit(cTrap)
  );

  // Answer in the same cycle as the reference
  always_comb
  begin
    abortAny = relocOn && refValid && (cAcc || cLen || cRo || badMode);
    physAddr = relocOn ? {physBlock, virtAddr[5:0]}
      : ((virtAddr[15:12] == 4'hF) ? {2'h3, virtAddr} : {2'h0, virtAddr});
    refAbort = abortAny;
    trapPending = s_q.trapReq;
    mapMode = s_q.vecPhase ? 2'h0 : curMode;
    stackMode = vecNewStatus[15:14];
    // Trap fires only at an instruction boundary
    takeTrap = instrEnd && s_q.trapReq;
    case (regSel)
      `VPR_SEL_BASE: regRdata = s_q.base[regIdx(regMode, regDspace, regPage)];
      `VPR_SEL_DESC: regRdata = s_q.desc[regIdx(regMode, regDspace, regPage)]
        & `VPR_DESC_WMASK | (s_q.desc[regIdx(regMode, regDspace, regPage)]
        & 16'h0_0C0);
      `VPR_SEL_MAIN: regRdata = s_q.main;
      default: regRdata = {13'h0000, s_q.dspace};
    endcase
  end

  // Next state: register writes, flag logging and trap scheduling
  always_comb
  begin
    logic [5:0] wi;
    logic frozen;
    wi = regIdx(regMode, regDspace, regPage);
    frozen = |s_q.main[15:13];
    s_d = s_q;
    // Clear first so that a trap raised in the same cycle is not lost
    if (takeTrap)
      s_d.trapReq = 1'b0;
    // Hardware logging of accessed and written flags
    if (relocOn && refValid && !abortAny)
    begin
      if (cTrap)
        s_d.desc[idx][`VPR_DESC_ACCD] = 1'b1;
      if (isWrite)
        s_d.desc[idx][`VPR_DESC_WRIT] = 1'b1;
      if (cTrap && s_q.main[`VPR_MAIN_TRAPEN])
        s_d.trapReq = 1'b1;
    end
    // Record fault status unless already frozen
    if (abortAny && !frozen)
    begin
      s_d.main[15] = cAcc || badMode;
      s_d.main[14] = cLen;
      s_d.main[13] = cRo;
      s_d.main[6:5] = effMode;
      s_d.main[4] = useD;
      s_d.main[3:1] = virtAddr[15:13];
    end
    if (relocOn && refValid && !abortAny && cTrap &&
        s_q.main[`VPR_MAIN_TRAPEN])
      s_d.main[12] = 1'b1;
    // Vectored transfer: kernel set until new status known
    s_d.state = s_q.state;
    case (s_q.state)
      VPR_ST_IDLE:
        if (vecStart)
        begin
          s_d.vecPhase = 1'b1;
          s_d.state = VPR_ST_VECTOR;
        end
      VPR_ST_VECTOR:
        if (instrEnd)
        begin
          s_d.vecPhase = 1'b0;
          s_d.vecMode = vecNewStatus[15:14];
          s_d.state = VPR_ST_IDLE;
        end
      default:
        s_d.state = VPR_ST_IDLE;
    endcase
    // Software writes; writing base or descriptor clears the flags
    if (regWrite)
    begin
      case (regSel)
        `VPR_SEL_BASE:
        begin
          s_d.base[wi] = regWdata;
          s_d.desc[wi][7:6] = 2'h0;
        end
        `VPR_SEL_DESC:
          s_d.desc[wi] = regWdata & `VPR_DESC_WMASK;
        `VPR_SEL_MAIN:
          s_d.main = (s_q.main & ~`VPR_MAIN_WMASK & 16'h0_0FE)
            | (regWdata & `VPR_MAIN_WMASK) | (regWdata & 16'hF_000);
        default:
          s_d.dspace = regWdata[2:0];
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.main <= `VPR_MAIN_RST;
      s_q.dspace <= `VPR_DSPACE_RST;
      s_q.state <= VPR_ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  // Checks
  chk_ro_write_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
    relocOn && refValid && isWrite && curDesc[2:1] == 2'h0 && curDesc[0]
    |-> refAbort) else $error("write to read-only page not aborted");
  chk_reloc_off_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
    !relocOn && virtAddr[15:12] != 4'hF |-> physAddr == {2'h0, virtAddr}
    && !refAbort) else $error("unrelocated address changed");
  chk_phys_form: assert property (@(posedge sys_clk) disable iff (!rstn)
    relocOn |-> physAddr[5:0] == virtAddr[5:0] && physAddr[17:6] ==
    12'(curBase + virtAddr[12:6])) else $error("bad physical address");
  chk_desc_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    regSel == `VPR_SEL_DESC |-> regRdata[15] == 1'b0 && regRdata[5:4] == 2'h0)
    else $error("reserved descriptor bits set");
  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && regSel == `VPR_SEL_BASE ##1 regSel == `VPR_SEL_DESC &&
    $stable(regPage) && $stable(regMode) && $stable(regDspace) && !refValid
    |-> regRdata[7:6] == 2'h0) else $error("flags not cleared");
  chk_trap_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
    takeTrap |-> instrEnd && trapPending)
    else $error("trap taken mid instruction");
  chk_trap_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    !s_q.main[9] && !s_q.trapReq && !regWrite |=> !trapPending)
    else $error("trap queued while disabled");
  chk_noncode_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
    relocOn && refValid && curDesc[1:0] == 2'h3 |-> refAbort)
    else $error("reserved code not aborted");
  chk_len_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
    relocOn && refValid && !curDesc[3] && virtAddr[12:6] > curDesc[14:8]
    |-> refAbort) else $error("length error not aborted");
endmodule : vpr_unit

// ===== sim/vpr_core_model.sv
// Behavioural processor core that issues virtual references
`timescale 1ns/1ps
module vpr_core_model (
  // Clock
  input wire logic sys_clk,
  // Reference towards the unit
  output logic refValid,
  output logic [15:0] virtAddr,
  output logic [1:0] curMode,
  output logic isInstr,
  output logic isWrite,
  // Instruction boundaries and vectored transfers
  output logic instrEnd,
  output logic vecStart,
  output logic [15:0] vecNewStatus
);
  // Quiet core at time zero
  initial
  begin
    refValid = 1'b0;
    virtAddr = 16'hA5A5;
    curMode = 2'h0;
    isInstr = 1'b0;
    isWrite = 1'b0;
    instrEnd = 1'b0;
    vecStart = 1'b0;
    vecNewStatus = 16'h0000;
  end
  // Whole reference held for one cycle, answer read before the edge
  task automatic issue(input logic [15:0] a, input logic [1:0] m,
                       input logic i, input logic w);
    @(negedge sys_clk);
    refValid = 1'b1;
    virtAddr = a;
    curMode = m;
    isInstr = i;
    isWrite = w;
    #5;
  endtask : issue
  // Released address flips so a stale value never looks valid
  task automatic idle();
    @(negedge sys_clk);
    refValid = 1'b0;
    virtAddr = ~virtAddr;
    isWrite = 1'b0;
  endtask : idle
  // Boundary and vector strobes
  task automatic pulse(input logic e, input logic v, input logic [15:0] s);
    @(negedge sys_clk);
    instrEnd = e;
    vecStart = v;
    vecNewStatus = s;
    #5;
  endtask : pulse
endmodule : vpr_core_model

// ===== sim/vpr_unit_bench.sv
// Self-checking bench for the relocation unit
`timescale 1ns/1ps
`include "vpr_regs.svh"
module vpr_unit_bench;
  localparam logic [1:0] SB = `VPR_SEL_BASE;
  localparam logic [1:0] SD = `VPR_SEL_DESC;
  localparam logic [1:0] SM = `VPR_SEL_MAIN;
  localparam logic [1:0] SS = `VPR_SEL_DSPACE;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic refValid, isInstr, isWrite, instrEnd, vecStart;
  logic [15:0] virtAddr, vecNewStatus, regRdata;
  logic [1:0] curMode, mapMode, stackMode;
  logic [17:0] physAddr;
  logic refAbort, trapPending, takeTrap;
  logic regWrite = 1'b0;
  logic regDspace = 1'b0;
  logic [1:0] regSel = 2'h0;
  logic [1:0] regMode = 2'h0;
  logic [2:0] regPage = 3'h0;
  logic [15:0] regWdata = 16'h0000;
  int nErrors = 0;
  int checked = 0;
  // Design and core model
  vpr_unit dut_u (.sys_clk, .rstn, .refValid, .virtAddr, .curMode,
    .isInstr, .isWrite, .instrEnd, .vecStart, .vecNewStatus, .physAddr,
    .refAbort, .trapPending, .mapMode, .stackMode, .takeTrap, .regWrite,
    .regSel, .regMode, .regDspace, .regPage, .regWdata, .regRdata);
  vpr_core_model core_u (.sys_clk, .refValid, .virtAddr, .curMode,
    .isInstr, .isWrite, .instrEnd, .vecStart, .vecNewStatus);
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Register port access; a read compares against v
  task automatic regAcc(input logic wr, input logic [1:0] s,
    input logic [1:0] m, input logic d, input logic [2:0] p,
    input logic [15:0] v);
    @(negedge sys_clk);
    regWrite = wr;
    regSel = s;
    regMode = m;
    regDspace = d;
    regPage = p;
    regWdata = v;
    #5;
    if (!wr)
      chk(18'(regRdata), 18'(v));
    @(negedge sys_clk);
    regWrite = 1'b0;
  endtask : regAcc
  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Watchdog well beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    nErrors++;
    conclude();
  end
  // Test sequence
  initial
  begin
    logic [2:0] ac;
    logic ra, wa, tp;
    logic [1:0] md [4] = '{2'h0, 2'h0, 2'h3, 2'h3};
    logic [17:0] ex [4] = '{18'h0_4155, 18'h0_0555, 18'h0_8155, 18'h0_8155};
    logic [15:0] la [4] = '{16'h20C0, 16'h2100, 16'h3EC0, 16'h3F00};
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    regAcc(0, SM, 2'h0, 1'b0, 3'h0, 16'h0_080);
    regAcc(0, SS, 2'h0, 1'b0, 3'h0, 16'h0_000);
    core_u.issue(16'hF000, 2'h0, 1'b1, 1'b0);
    chk(physAddr, 18'h3_F000);
    chk(18'(refAbort), 18'h0);
    core_u.idle();
    core_u.issue(16'h1234, 2'h0, 1'b1, 1'b0);
    chk(physAddr, 18'h0_1234);
    core_u.idle();
    $display("test reset done");
    regAcc(1, SB, 2'h0, 1'b0, 3'h1, 16'hF010);
    regAcc(1, SD, 2'h0, 1'b0, 3'h1, 16'hFF36);
    regAcc(0, SD, 2'h0, 1'b0, 3'h1, 16'h7F06);
    regAcc(1, SM, 2'h0, 1'b0, 3'h0, 16'h0_001);
    core_u.issue(16'h2155, 2'h0, 1'b1, 1'b0);
    chk(physAddr, 18'h0_0555);
    core_u.idle();
    $display("test translate done");
    // Every access code, read then write, with traps enabled
    for (int k = 0; k < 16; k++)
    begin
      ac = k[3:1];
      ra = (ac == 3'h0) || (ac == 3'h3) || (ac == 3'h7);
      wa = ra || (ac == 3'h1) || (ac == 3'h2);
      tp = k[0] ? (ac == 3'h4 || ac == 3'h5) : (ac == 3'h1 || ac == 3'h4);
      tp = tp && !(k[0] ? wa : ra);
      regAcc(1, SM, 2'h0, 1'b0, 3'h0, 16'h0_201);
      regAcc(1, SD, 2'h0, 1'b0, 3'h1, {8'h7F, 5'h00, ac});
      core_u.issue(16'h2155, 2'h0, 1'b1, k[0]);
      chk(18'(refAbort), 18'(k[0] ? wa : ra));
      core_u.idle();
      chk(18'(trapPending), 18'(tp));
      core_u.pulse(1'b1, 1'b0, 16'h0000);
      chk(18'(takeTrap), 18'(tp));
      core_u.pulse(1'b0, 1'b0, 16'h0000);
      regAcc(0, SD, 2'h0, 1'b0, 3'h1,
             {8'h7F, tp, k[0] && !wa, 3'h0, ac});
    end
    // Code 100 with traps off: flag logged, nothing queued
    regAcc(1, SM, 2'h0, 1'b0, 3'h0, 16'h0_001);
    regAcc(1, SD, 2'h0, 1'b0, 3'h1, 16'h7F04);
    core_u.issue(16'h2155, 2'h0, 1'b1, 1'b0);
    core_u.idle();
    chk(18'(trapPending), 18'h0);
    regAcc(0, SD, 2'h0, 1'b0, 3'h1, 16'h7F84);
    // Base write followed at once by a descriptor read
    @(negedge sys_clk);
    regWrite = 1'b1;
    regSel = SB;
    regMode = 2'h0;
    regDspace = 1'b0;
    regPage = 3'h1;
    regWdata = 16'h0_010;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regSel = SD;
    #5;
    chk(18'(regRdata), 18'h0_7F04);
    $display("test access done");
    // Length bound at both edges, upward then downward
    for (int k = 0; k < 4; k++)
    begin
      regAcc(1, SD, 2'h0, 1'b0, 3'h1, k < 2 ? 16'h0306 : 16'h7C0E);
      core_u.issue(la[k], 2'h0, 1'b1, 1'b0);
      chk(18'(refAbort), 18'(k == 1 || k == 2));
      core_u.idle();
    end
    $display("test length done");
    regAcc(1, SD, 2'h0, 1'b0, 3'h1, 16'h7F06);
    regAcc(1, SB, 2'h0, 1'b1, 3'h1, 16'h0_100);
    regAcc(1, SD, 2'h0, 1'b1, 3'h1, 16'h7F06);
    regAcc(1, SB, 2'h3, 1'b0, 3'h1, 16'h0_200);
    regAcc(1, SD, 2'h3, 1'b0, 3'h1, 16'h7F06);
    core_u.issue(16'h2155, 2'h0, 1'b0, 1'b0);
    chk(physAddr, 18'h0_0555);
    core_u.idle();
    regAcc(1, SS, 2'h0, 1'b0, 3'h0, 16'h0_004);
    // Space and mode selection of the register set
    for (int k = 0; k < 4; k++)
    begin
      core_u.issue(16'h2155, md[k], k == 1 || k == 2, 1'b0);
      chk(physAddr, ex[k]);
      core_u.idle();
    end
    $display("test space done");
    regAcc(1, SS, 2'h0, 1'b0, 3'h0, 16'h0_000);
    regAcc(1, SB, 2'h0, 1'b0, 3'h0, 16'h0_040);
    regAcc(1, SD, 2'h0, 1'b0, 3'h0, 16'h7F06);
    for (int k = 0; k < 3; k++)
    begin
      core_u.pulse(1'b0, 1'b1, {k == 0 ? 2'h0 : 2'(4 - k), 14'h0});
      chk(18'(stackMode), 18'(k == 0 ? 2'h0 : 2'(4 - k)));
    end
    core_u.pulse(1'b0, 1'b0, 16'h4000);
    core_u.issue(16'h00A8, 2'h3, 1'b0, 1'b0);
    chk(physAddr, 18'h0_10A8);
    chk(18'(mapMode), 18'h0);
    core_u.idle();
    core_u.pulse(1'b1, 1'b0, 16'h4000);
    core_u.pulse(1'b0, 1'b0, 16'h4000);
    core_u.issue(16'h2155, 2'h1, 1'b1, 1'b0);
    chk(18'(mapMode), 18'h1);
    core_u.idle();
    $display("test vector done");
    conclude();
  end
endmodule : vpr_unit_bench
